// file: pkg/timer_option_pkg.sv
package timer_option_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses of 32-bit words
   // ----------------------------------------------------------------
   localparam int             ADDR_W      = 8;
   localparam logic [7:0]     OPT_ADDR    = 8'h00;
   localparam logic [7:0]     FILE01_ADDR = 8'h04;
   localparam logic [7:0]     WORK_ADDR   = 8'h08;
   localparam logic [7:0]     CNT_ADDR    = 8'h0c;
   localparam logic [7:0]     STAT_ADDR   = 8'h10;

   // ----------------------------------------------------------------
   // Reset values and field layout
   // ----------------------------------------------------------------
   localparam logic [7:0]     OPT_RESET   = 8'hff;
   localparam logic [7:0]     CNT_RESET   = 8'h00;
   localparam logic [7:0]     WORK_RESET  = 8'h00;
   localparam logic [7:0]     LOCK_MASK   = 8'hc0;
   localparam logic [7:0]     CNT_MAX     = 8'hff;
   localparam int             STAT_LOCK   = 0;
   localparam int             STAT_PSC_LSB = 8;
   localparam int             PSC_W       = 8;

   // AXI4-Lite response codes
   localparam logic [1:0]     RESP_OKAY   = 2'b00;
   localparam logic [1:0]     RESP_SLVERR = 2'b10;

   // Option register fields, bit 7 first
   typedef struct packed {
      logic       file01_select;
      logic       rollover_irq_disable;
      logic       count_source;
      logic       count_edge_select;
      logic       prescaler_assign;
      logic [2:0] prescale_ratio_code;
   } option_type;

endpackage

// file: rtl/count_source_select.sv
`timescale 1ns/1ps
module count_source_select (
   input  wire logic                        core_clk_in,
   input  wire logic                        rst_n_in,
   input  wire logic                        count_pin_in,
   input  wire timer_option_pkg::option_type opt_in,
   output logic                             src_tick_out
);

   logic pin_prev_ff;
   logic rise;
   logic fall;

   // ----------------------------------------------------------------
   // Pin history
   // ----------------------------------------------------------------
   // Loaded from the pin during reset so no false edge at release
   always_ff @(posedge core_clk_in) begin
      pin_prev_ff <= count_pin_in;
   end

   // Edge pick and source pick
   assign rise = count_pin_in & ~pin_prev_ff;
   assign fall = ~count_pin_in & pin_prev_ff;
   always_comb begin
      if (opt_in.count_source) begin
         src_tick_out = opt_in.count_edge_select ? fall : rise;
      end else begin
         src_tick_out = 1'b1;
      end
   end

endmodule

// file: rtl/shared_prescaler.sv
`timescale 1ns/1ps
module shared_prescaler #(
   parameter int WIDTH = 8
) (
   input  wire logic                        core_clk_in,
   input  wire logic                        rst_n_in,
   input  wire logic                        clear_in,
   input  wire logic                        src_tick_in,
   input  wire timer_option_pkg::option_type opt_in,
   output logic                             cnt_tick_out,
   output logic                             watchdog_tick_out,
   output logic [WIDTH-1:0]                 count_out
);

   logic [WIDTH-1:0] psc_ff;
   logic [WIDTH:0]   span;
   logic [WIDTH-1:0] mask;
   logic             psc_in;
   logic             psc_tick;

   // Watchdog side runs off the instruction cycle itself
   assign psc_in = opt_in.prescaler_assign ? 1'b1 : src_tick_in;

   // ----------------------------------------------------------------
   // Divide ratio: one more stage when feeding the counter
   // ----------------------------------------------------------------
   always_comb begin
      if (opt_in.prescaler_assign) begin
         span = (WIDTH+1)'(1) << opt_in.prescale_ratio_code;
      end else begin
         span = (WIDTH+1)'(2) << opt_in.prescale_ratio_code;
      end
      mask = WIDTH'(span - (WIDTH+1)'(1));
   end

   assign psc_tick = psc_in & ((psc_ff & mask) == mask);

   // Ripple count; cleared on option writes to avoid a stale phase
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || clear_in) begin
         psc_ff <= '0;
      end else if (psc_in) begin
         psc_ff <= psc_ff + WIDTH'(1);
      end
   end

   // Routing of the divided tick
   assign cnt_tick_out      = opt_in.prescaler_assign ? src_tick_in
                                                      : psc_tick;
   assign watchdog_tick_out = opt_in.prescaler_assign ? psc_tick : 1'b1;
   assign count_out         = psc_ff;

endmodule

// file: rtl/timer_option_ctrl.sv
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - Lock clear: bits 7,6 writable, active
// - Lock set: bits 7,6 read as ones
// - File 01h is W or counter
// - Irq-disable bit 0 enables, 1 suppresses
// - Count source: instruction cycle or pin
// - Pin edge: 0 rising, 1 falling
// - Assign 0: prescaler before counter
// - Assign 1: watchdog prescaled, counter undivided
// - Counter divide is two to code+1
// - Watchdog divide is two to code
// - Reset sets all option bits
// - Config_word_a lock bit constant while running
// - Counter is an 8-bit file register
module timer_option_ctrl (
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        option_lock_config_word_a_in,
   input  wire logic        count_pin_in,
   input  wire logic        awvalid_in,
   output logic             awready_out,
   input  wire logic [7:0]  awaddr_in,
   input  wire logic        wvalid_in,
   output logic             wready_out,
   input  wire logic [31:0] wdata_in,
   input  wire logic [3:0]  wstrb_in,
   output logic             bvalid_out,
   input  wire logic        bready_in,
   output logic [1:0]       bresp_out,
   input  wire logic        arvalid_in,
   output logic             arready_out,
   input  wire logic [7:0]  araddr_in,
   output logic             rvalid_out,
   input  wire logic        rready_in,
   output logic [31:0]      rdata_out,
   output logic [1:0]       rresp_out,
   output logic [7:0]       realtime_counter_out,
   output logic             rollover_irq_out,
   output logic             watchdog_tick_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   timer_option_pkg::option_type opt_ff;
   logic       lock_ff;
   logic [7:0] cnt_ff;
   logic [7:0] work_ff;
   logic       irq_ff;
   logic       watchdog_ff;
   logic       aw_hold_ff;
   logic       w_hold_ff;
   logic [7:0] waddr_ff;
   logic [7:0] wbyte_ff;
   logic       wlane_ff;
   logic       awready_ff;
   logic       wready_ff;
   logic       bvalid_ff;
   logic [1:0] bresp_ff;
   logic       arready_ff;
   logic       rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic       nxt_aw_hold;
   logic       nxt_w_hold;
   logic       nxt_ar_busy;
   logic       wr_fire;
   logic       wr_hit;
   logic       opt_wr;
   logic       cnt_wr;
   logic       work_wr;
   logic       rd_fire;
   logic [31:0] rd_data;
   logic       rd_hit;
   logic       src_tick;
   logic       cnt_tick;
   logic       watchdog_tick;
   logic [timer_option_pkg::PSC_W-1:0] psc_count;

   // ----------------------------------------------------------------
   // Count source and shared prescaler
   // ----------------------------------------------------------------
   count_source_select u_src (
      .core_clk_in  (core_clk_in),
      .rst_n_in     (rst_n_in),
      .count_pin_in (count_pin_in),
      .opt_in       (opt_ff),
      .src_tick_out (src_tick)
   );

   shared_prescaler #(
      .WIDTH (timer_option_pkg::PSC_W)
   ) u_psc (
      .core_clk_in   (core_clk_in),
      .rst_n_in      (rst_n_in),
      .clear_in      (opt_wr),
      .src_tick_in   (src_tick),
      .opt_in        (opt_ff),
      .cnt_tick_out  (cnt_tick),
      .watchdog_tick_out (watchdog_tick),
      .count_out     (psc_count)
   );

   // ----------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ----------------------------------------------------------------
   assign wr_fire = aw_hold_ff & w_hold_ff & ~bvalid_ff;

   // Holds drop when the response is accepted
   always_comb begin
      nxt_aw_hold = aw_hold_ff | (awvalid_in & awready_ff);
      nxt_w_hold  = w_hold_ff | (wvalid_in & wready_ff);
      if (bvalid_ff && bready_in) begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold  = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         w_hold_ff  <= nxt_w_hold;
         awready_ff <= ~nxt_aw_hold;
         wready_ff  <= ~nxt_w_hold;
      end
   end

   // Captured payload
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         waddr_ff <= 8'h00;
         wbyte_ff <= 8'h00;
         wlane_ff <= 1'b0;
      end else begin
         if (awvalid_in && awready_ff) begin
            waddr_ff <= awaddr_in;
         end
         if (wvalid_in && wready_ff) begin
            wbyte_ff <= wdata_in[7:0];
            wlane_ff <= wstrb_in[0];
         end
      end
   end

   // Only byte lane 0 carries data; other lanes are ignored
   assign wr_hit  = (waddr_ff == timer_option_pkg::OPT_ADDR)
                  | (waddr_ff == timer_option_pkg::FILE01_ADDR)
                  | (waddr_ff == timer_option_pkg::WORK_ADDR)
                  | (waddr_ff == timer_option_pkg::CNT_ADDR)
                  | (waddr_ff == timer_option_pkg::STAT_ADDR);
   assign opt_wr  = wr_fire & wlane_ff
                  & (waddr_ff == timer_option_pkg::OPT_ADDR);
   assign cnt_wr  = wr_fire & wlane_ff
                  & ((waddr_ff == timer_option_pkg::CNT_ADDR)
                  | ((waddr_ff == timer_option_pkg::FILE01_ADDR)
                  & opt_ff.file01_select));
   assign work_wr = wr_fire & wlane_ff
                  & ((waddr_ff == timer_option_pkg::WORK_ADDR)
                  | ((waddr_ff == timer_option_pkg::FILE01_ADDR)
                  & ~opt_ff.file01_select));

   // Response; unmapped addresses answer SLVERR
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= timer_option_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_hit ? timer_option_pkg::RESP_OKAY
                             : timer_option_pkg::RESP_SLVERR;
      end else if (bready_in) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read channel: one read in flight
   // ----------------------------------------------------------------
   assign rd_fire = arvalid_in & arready_ff;

   always_comb begin
      nxt_ar_busy = rd_fire | (rvalid_ff & ~rready_in);
   end

   // Read mux; the file 01h window follows the select bit
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (araddr_in)
         timer_option_pkg::OPT_ADDR:    rd_data[7:0] = opt_ff;
         timer_option_pkg::FILE01_ADDR: begin
            rd_data[7:0] = opt_ff.file01_select ? cnt_ff
                                                : work_ff;
         end
         timer_option_pkg::WORK_ADDR:   rd_data[7:0] = work_ff;
         timer_option_pkg::CNT_ADDR:    rd_data[7:0] = cnt_ff;
         timer_option_pkg::STAT_ADDR: begin
            rd_data[timer_option_pkg::STAT_LOCK] = lock_ff;
            rd_data[timer_option_pkg::STAT_PSC_LSB +: 8] = psc_count;
         end
         default:                       rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= timer_option_pkg::RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_ar_busy;
         if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_data;
            rresp_ff  <= rd_hit ? timer_option_pkg::RESP_OKAY
                                : timer_option_pkg::RESP_SLVERR;
         end else if (rready_in) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Option register and config_word_a lock
   // ----------------------------------------------------------------
   // Config_word_a is sampled only while reset is held, then frozen
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         lock_ff <= option_lock_config_word_a_in;
      end
   end

   // Locked upper bits stay at one whatever is written
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         opt_ff <= timer_option_pkg::OPT_RESET;
      end else if (opt_wr) begin
         if (lock_ff) begin
            opt_ff <= wbyte_ff | timer_option_pkg::LOCK_MASK;
         end else begin
            opt_ff <= wbyte_ff;
         end
      end
   end

   // ----------------------------------------------------------------
   // Working register and real-time counter
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         work_ff <= timer_option_pkg::WORK_RESET;
      end else if (work_wr) begin
         work_ff <= wbyte_ff;
      end
   end

   // A software load wins over a tick in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         cnt_ff <= timer_option_pkg::CNT_RESET;
      end else if (cnt_wr) begin
         cnt_ff <= wbyte_ff;
      end else if (cnt_tick) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // Roll-over request, one cycle, gated by the disable bit
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         irq_ff <= 1'b0;
         watchdog_ff <= 1'b0;
      end else begin
         irq_ff <= cnt_tick & ~cnt_wr
                 & (cnt_ff == timer_option_pkg::CNT_MAX)
                 & ~opt_ff.rollover_irq_disable;
         watchdog_ff <= watchdog_tick;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign awready_out          = awready_ff;
   assign wready_out           = wready_ff;
   assign bvalid_out           = bvalid_ff;
   assign bresp_out            = bresp_ff;
   assign arready_out          = arready_ff;
   assign rvalid_out           = rvalid_ff;
   assign rdata_out            = rdata_ff;
   assign rresp_out            = rresp_ff;
   assign realtime_counter_out = cnt_ff;
   assign rollover_irq_out     = irq_ff;
   assign watchdog_tick_out    = watchdog_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_opt_write_open;
      opt_wr && !lock_ff;
   endsequence

   sequence s_wrap_enabled;
      cnt_tick && !cnt_wr && cnt_ff == timer_option_pkg::CNT_MAX
         && !opt_ff.rollover_irq_disable;
   endsequence

   a_open_bits_write: assert property (
      s_opt_write_open |=> opt_ff[7:6] == $past(wbyte_ff[7:6]))
      else $error("upper option bits not written while unlocked");
   a_locked_bits_one: assert property (
      lock_ff |-> opt_ff[7:6] == 2'b11)
      else $error("locked option bits not reading ones");
   a_file01_window: assert property (
      rd_fire && araddr_in == timer_option_pkg::FILE01_ADDR |=>
         rdata_ff[7:0] == ($past(opt_ff.file01_select)
                          ? $past(cnt_ff) : $past(work_ff)))
      else $error("file 01h window returned wrong register");
   a_irq_disabled: assert property (
      rollover_irq_out |-> !$past(opt_ff.rollover_irq_disable))
      else $error("roll-over request while disabled");
   a_cycle_source: assert property (
      opt_ff.prescaler_assign && !opt_ff.count_source |-> cnt_tick)
      else $error("counter missed an instruction cycle");
   a_edge_select: assert property (
      opt_ff.prescaler_assign && opt_ff.count_source
         && !opt_ff.count_edge_select && $rose(count_pin_in)
         |-> cnt_tick)
      else $error("rising pin edge not counted");
   a_half_rate: assert property (
      !opt_ff.prescaler_assign && !opt_ff.count_source
         && opt_ff.prescale_ratio_code == 3'b000 && !opt_wr
         && cnt_tick |=> !cnt_tick)
      else $error("counter divide by two broken");
   a_watchdog_route: assert property (
      opt_ff.prescaler_assign |-> cnt_tick == src_tick)
      else $error("counter divided while prescaler on watchdog");
   a_watchdog_unity: assert property (
      opt_ff.prescaler_assign && opt_ff.prescale_ratio_code == 3'b000
         |=> watchdog_tick_out)
      else $error("watchdog divide 1:1 broken");
   a_reset_ones: assert property (
      @(posedge core_clk_in) disable iff (1'b0)
      !rst_n_in |=> opt_ff == timer_option_pkg::OPT_RESET)
      else $error("option register not all ones after reset");
   a_lock_stable: assert property (
      ##1 $stable(lock_ff))
      else $error("config_word_a lock changed while running");
   a_wrap_irq: assert property (
      s_wrap_enabled |=> rollover_irq_out && cnt_ff == 8'h00)
      else $error("wrap did not raise request");

endmodule

// file: testbench/test_timer_option_ctrl.sv
`timescale 1ns/1ps
module test_timer_option_ctrl;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        core_clk_in;
   logic        rst_n_in;
   logic        option_lock_config_word_a_in;
   logic        count_pin_in;
   logic        awvalid_in;
   logic        awready_out;
   logic [7:0]  awaddr_in;
   logic        wvalid_in;
   logic        wready_out;
   logic [31:0] wdata_in;
   logic [3:0]  wstrb_in;
   logic        bvalid_out;
   logic        bready_in;
   logic [1:0]  bresp_out;
   logic        arvalid_in;
   logic        arready_out;
   logic [7:0]  araddr_in;
   logic        rvalid_out;
   logic        rready_in;
   logic [31:0] rdata_out;
   logic [1:0]  rresp_out;
   logic [7:0]  realtime_counter_out;
   logic        rollover_irq_out;
   logic        watchdog_tick_out;
   int          n_mismatch;
   int          num_checks;
   logic [1:0]  resp;
   logic [31:0] rd;
   logic [7:0]  dcnt;
   int          ticks;
   int          irqs;

   typedef struct {
      logic [7:0] opt;
      int         win;
      logic [7:0] dcnt;
      int         wtick;
   } row_type;
   row_type     rows [16];

   timer_option_ctrl dut (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .option_lock_config_word_a_in(option_lock_config_word_a_in),
      .count_pin_in(count_pin_in),
      .awvalid_in(awvalid_in), .awready_out(awready_out),
      .awaddr_in(awaddr_in), .wvalid_in(wvalid_in),
      .wready_out(wready_out), .wdata_in(wdata_in),
      .wstrb_in(wstrb_in), .bvalid_out(bvalid_out),
      .bready_in(bready_in), .bresp_out(bresp_out),
      .arvalid_in(arvalid_in), .arready_out(arready_out),
      .araddr_in(araddr_in), .rvalid_out(rvalid_out),
      .rready_in(rready_in), .rdata_out(rdata_out),
      .rresp_out(rresp_out),
      .realtime_counter_out(realtime_counter_out),
      .rollover_irq_out(rollover_irq_out),
      .watchdog_tick_out(watchdog_tick_out)
   );

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end

   // Whole run is about 1800 cycles; 25000 leaves ample margin
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic end_of_test;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t response %b expected %b", $time, got, exp);
      end
   endtask

   // Config_word_a level is latched while reset is low, so it moves with it
   task automatic do_reset(input logic lock);
      rst_n_in <= 1'b0;
      option_lock_config_word_a_in <= lock;
      repeat (5) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk_in);
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      awaddr_in <= a;
      wdata_in <= {24'h000000, d};
      bready_in <= 1'b1;
      do begin
         @(posedge core_clk_in);
         n++;
         if (awvalid_in && awready_out) awvalid_in <= 1'b0;
         if (wvalid_in && wready_out) wvalid_in <= 1'b0;
      end while (!(bvalid_out && bready_in) && n < 100);
      resp = bresp_out;
      bready_in <= 1'b0;
      if (n >= 100) begin
         n_mismatch++;
         $display("[FAIL] %0t write handshake timed out", $time);
      end
   endtask

   task automatic rdr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge core_clk_in);
      arvalid_in <= 1'b1;
      araddr_in <= a;
      rready_in <= 1'b1;
      do begin
         @(posedge core_clk_in);
         n++;
         if (arvalid_in && arready_out) arvalid_in <= 1'b0;
      end while (!(rvalid_out && rready_in) && n < 100);
      rd = rdata_out;
      resp = rresp_out;
      rready_in <= 1'b0;
      if (n >= 100) begin
         n_mismatch++;
         $display("[FAIL] %0t read handshake timed out", $time);
      end
   endtask

   // Window is a whole number of periods, so prescaler phase is moot
   task automatic measure(input int w);
      logic [7:0] s;
      @(negedge core_clk_in);
      s = realtime_counter_out;
      ticks = 0;
      irqs = 0;
      repeat (w) begin
         @(negedge core_clk_in);
         ticks += int'(watchdog_tick_out === 1'b1);
         if (rollover_irq_out === 1'b1) begin
            irqs++;
            chk_val(realtime_counter_out, 32'h00000000);
         end
      end
      dcnt = realtime_counter_out - s;
   endtask

   task automatic pulses(input int k);
      repeat (k) begin
         @(posedge core_clk_in);
         count_pin_in <= 1'b1;
         repeat (3) @(posedge core_clk_in);
         count_pin_in <= 1'b0;
         repeat (3) @(posedge core_clk_in);
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n_in = 1'b0;
      option_lock_config_word_a_in = 1'b0;
      count_pin_in = 1'b0;
      awvalid_in = 1'b0;
      wvalid_in = 1'b0;
      arvalid_in = 1'b0;
      awaddr_in = 8'h00;
      araddr_in = 8'h00;
      wdata_in = 32'h00000000;
      wstrb_in = 4'h1;
      bready_in = 1'b0;
      rready_in = 1'b0;
      n_mismatch = 0;
      num_checks = 0;
      // Irq off, cycle source; rows 0-7 counter, 8-15 watchdog
      for (int i = 0; i < 16; i++) begin
         rows[i].opt = {4'b1100, i[3], i[2:0]};
         rows[i].win = i < 8 ? 4 << i : 2 << (i - 8);
         rows[i].dcnt = i < 8 ? 8'h02 : rows[i].win[7:0];
         rows[i].wtick = i < 8 ? rows[i].win : 2;
      end
      do_reset(1'b0);
      foreach (rows[i]) begin
         wr(timer_option_pkg::OPT_ADDR, rows[i].opt);
         measure(rows[i].win);
         chk_val(dcnt, rows[i].dcnt);
         chk_val(ticks, rows[i].wtick);
      end
      // Second reset in mid-run restores all ones
      @(posedge core_clk_in); // Measure ends on a falling edge
      do_reset(1'b0);
      rdr(timer_option_pkg::OPT_ADDR);
      chk_val(rd, 32'h000000ff);
      chk_resp(resp, timer_option_pkg::RESP_OKAY);
      // Pin source with pin idle keeps the counter still
      wr(timer_option_pkg::OPT_ADDR, 8'h68);
      chk_resp(resp, timer_option_pkg::RESP_OKAY);
      rdr(timer_option_pkg::OPT_ADDR);
      chk_val(rd, 32'h00000068);
      // Write without lane 0 must leave the register alone
      wstrb_in <= 4'he;
      wr(timer_option_pkg::OPT_ADDR, 8'h00);
      wstrb_in <= 4'h1;
      rdr(timer_option_pkg::OPT_ADDR);
      chk_val(rd, 32'h00000068);
      wr(timer_option_pkg::FILE01_ADDR, 8'h3c);
      rdr(timer_option_pkg::WORK_ADDR);
      chk_val(rd, 32'h0000003c);
      wr(timer_option_pkg::OPT_ADDR, 8'he8);
      wr(timer_option_pkg::FILE01_ADDR, 8'ha5);
      rdr(timer_option_pkg::CNT_ADDR);
      chk_val(rd, 32'h000000a5);
      rdr(timer_option_pkg::FILE01_ADDR);
      chk_val(rd, 32'h000000a5);
      rdr(timer_option_pkg::WORK_ADDR);
      chk_val(rd, 32'h0000003c);
      // Rising edges only, then falling edges only
      pulses(3);
      chk_val(realtime_counter_out, 32'h000000a8);
      wr(timer_option_pkg::OPT_ADDR, 8'hf8);
      pulses(3);
      chk_val(realtime_counter_out, 32'h000000ab);
      // Roll-over request enabled, then suppressed
      wr(timer_option_pkg::OPT_ADDR, 8'h88);
      wr(timer_option_pkg::CNT_ADDR, 8'hf0);
      measure(20);
      chk_val(irqs, 1);
      wr(timer_option_pkg::OPT_ADDR, 8'hc8);
      wr(timer_option_pkg::CNT_ADDR, 8'hf0);
      measure(20);
      chk_val(irqs, 0);
      // Unmapped address is refused both ways
      wr(8'h20, 8'h00);
      chk_resp(resp, timer_option_pkg::RESP_SLVERR);
      rdr(8'h20);
      chk_resp(resp, timer_option_pkg::RESP_SLVERR);
      chk_val(rd, 32'h00000000);
      // Locked part: config_word_a input moves after reset but must not matter
      do_reset(1'b1);
      @(posedge core_clk_in);
      option_lock_config_word_a_in <= 1'b0;
      wr(timer_option_pkg::OPT_ADDR, 8'h00);
      rdr(timer_option_pkg::OPT_ADDR);
      chk_val(rd, 32'h000000c0);
      rdr(timer_option_pkg::STAT_ADDR);
      chk_val(rd[timer_option_pkg::STAT_LOCK], 32'h00000001);
      end_of_test();
   end
endmodule
